// >>> hdl/gorf_pkg.sv
// Constants, types and helpers shared by the gyro offset, rate and filter
// configuration block. Assumes a 250 MHz core clock.
package gorf_pkg;

   // Core clock and internal sample periods in nanoseconds
   localparam int CLK_PERIOD_NS      = 4;
   localparam int RATE_32K_PERIOD_NS = 31250;
   localparam int RATE_8K_PERIOD_NS  = 125000;
   localparam int RATE_1K_PERIOD_NS  = 1000000;
   localparam int TICKS_32K          = RATE_32K_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TICKS_8K           = RATE_8K_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TICKS_1K           = RATE_1K_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TICK_W             = 18;

   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_Y_OFFS_HI = 6'h15;
   localparam logic [5:0] IDX_Y_OFFS_LO = 6'h16;
   localparam logic [5:0] IDX_Z_OFFS_HI = 6'h17;
   localparam logic [5:0] IDX_Z_OFFS_LO = 6'h18;
   localparam logic [5:0] IDX_RATE_DIV  = 6'h19;
   localparam logic [5:0] IDX_PATH_CFG  = 6'h1A;
   localparam logic [5:0] IDX_GYRO_CFG  = 6'h1B;

   // Field positions and values
   localparam int FIFO_MODE_BIT  = 6;
   localparam int SYNC_SEL_LSB   = 3;
   localparam int LPF_SET_LSB    = 0;
   localparam int BYPASS_LSB     = 0;
   localparam logic [7:0] REG_RESET   = 8'h00;
   localparam logic [1:0] BYPASS_NONE = 2'h0;
   localparam logic [2:0] LPF_SET_LOW  = 3'h0;
   localparam logic [2:0] LPF_SET_HIGH = 3'h7;

   // Sync placement codes
   localparam logic [2:0] SYNC_OFF     = 3'h0;
   localparam logic [2:0] SYNC_TEMP    = 3'h1;
   localparam logic [2:0] SYNC_GYRO_X  = 3'h2;
   localparam logic [2:0] SYNC_GYRO_Y  = 3'h3;
   localparam logic [2:0] SYNC_GYRO_Z  = 3'h4;
   localparam logic [2:0] SYNC_ACCEL_X = 3'h5;
   localparam logic [2:0] SYNC_ACCEL_Y = 3'h6;
   localparam logic [2:0] SYNC_ACCEL_Z = 3'h7;

   typedef enum logic [0:0] {
      APB_IDLE = 1'b0,
      APB_ACK  = 1'b1
   } gorf_apb_e;

   typedef enum logic [1:0] {
      RATE_1K  = 2'b00,
      RATE_8K  = 2'b01,
      RATE_32K = 2'b10
   } gorf_rate_e;

   typedef struct packed {
      logic [15:0] temp;
      logic [15:0] gyro_x;
      logic [15:0] gyro_y;
      logic [15:0] gyro_z;
      logic [15:0] accel_x;
      logic [15:0] accel_y;
      logic [15:0] accel_z;
   } gorf_sample_s;

   function automatic logic [7:0] reg_addr(input logic [5:0] idx);
      return {idx, 2'b00};
   endfunction

endpackage

// >>> hdl/gorf_sync_latch.sv
// Frame-sync pin catcher: synchroniser plus a toggle latch that holds one
// change until the sample strobe has taken it. Pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module gorf_sync_latch
   import gorf_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Pin and capture
   input  wire logic pin,
   input  wire logic capture,
   output logic      latched
);

   typedef struct packed {
      logic [2:0] sy;
      logic       prev;
      logic       latched;
      logic       armed;
   } gorf_latch_s;

   gorf_latch_s s;
   gorf_latch_s next_s;
   logic        change;

   always_comb
   begin
      next_s = s;
      next_s.sy = {s.sy[1:0], pin};
      change = (s.sy[1] == s.sy[2]) && (s.sy[2] != s.prev);
      if (capture)
      begin
         next_s.armed = 1'b1;
      end
      // One flip per capture interval; later changes wait for rearm
      if (change && s.armed)
      begin
         next_s.latched = ~s.latched;
         next_s.prev    = s.sy[2];
         next_s.armed   = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= '{sy: 3'h0, prev: 1'b0, latched: 1'b0, armed: 1'b1};
      end
      else
      begin
         s <= next_s;
      end
   end

   assign latched = s.latched;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_latch_flip_gated: assert property (
      $changed(s.latched) |-> $past(s.armed) && !s.armed)
      else $error("sync latch flipped while disarmed");
   a_latch_rearm: assert property (
      capture && !(change && s.armed) |=> s.armed)
      else $error("sync latch not rearmed by capture");

endmodule // gorf_sync_latch
`default_nettype wire

// >>> hdl/gorf_config.sv
// Gyro offset, sample-rate divider, FIFO policy, frame-sync placement and
// filter selection, reached over APB. Raw samples arrive on CORE_CLK.
//
// Summary of operation
// - Add signed 16-bit user offset to the Y and Z gyro axis samples before output.
// - Offset split: high byte register holds bits 15..8, low byte 7..0.
// - Output rate is 1 kHz divided by one plus the 8-bit divider.
// - Divider used only when bypass is zero and setting is between 0 and 7.
// - The divided strobe updates output registers and pushes the FIFO.
// - Mode bit 6 set drops writes when full; clear overwrites the oldest.
// - Field 5:3 places latched sync in bit 0 of chosen low byte; 0 off.
// - Sync pin latched; toggles once, then waits for the sample strobe.
// - Low-pass setting controls the filter only while bypass bits are zero.
// - Rate 32 kHz when bypassed; else 8 kHz for settings 0 and 7, else 1 kHz.
// - Bypass bits sit in bits 1:0 of the gyro configuration register.
// - All APB registers reset to zero; rate resets to 8 kHz, filter enable to one.
`timescale 1ns/1ps
`default_nettype none
module gorf_config
   import gorf_pkg::*;
#(
   parameter int unsigned TICKS_32K_P = TICKS_32K,
   parameter int unsigned TICKS_8K_P  = TICKS_8K,
   parameter int unsigned TICKS_1K_P  = TICKS_1K
)
(
   // Clock and reset
   input  wire logic         CORE_CLK,
   input  wire logic         RST_N,
   // APB slave
   input  wire logic         PSEL,
   input  wire logic         PENABLE,
   input  wire logic         PWRITE,
   input  wire logic [7:0]   PADDR,
   input  wire logic [31:0]  PWDATA,
   input  wire logic [3:0]   PSTRB,
   output logic [31:0]       PRDATA,
   output logic              PREADY,
   output logic              PSLVERR,
   // Sensor data path
   input  wire gorf_sample_s RAW_SAMPLE,
   input  wire logic         FRAME_SYNC_PIN,
   output gorf_sample_s      OUT_SAMPLE,
   output logic              SAMPLE_STROBE,
   // FIFO push control
   input  wire logic         FIFO_FULL,
   output logic              FIFO_WR,
   output logic              FIFO_OVERWRITE,
   output logic              FIFO_DROP,
   // Filter selection
   output logic              LPF_ENABLE,
   output logic [2:0]        LPF_SETTING,
   output gorf_rate_e        INTERNAL_RATE
);

   typedef struct packed {
      gorf_apb_e    apb;
      logic         pready;
      logic         pslverr;
      logic [31:0]  prdata;
      logic [7:0]   y_offs_hi;
      logic [7:0]   y_offs_lo;
      logic [7:0]   z_offs_hi;
      logic [7:0]   z_offs_lo;
      logic [7:0]   rate_div;
      logic [7:0]   path_cfg;
      logic [7:0]   gyro_cfg;
      logic [TICK_W-1:0] tick_cnt;
      logic [7:0]   div_cnt;
      logic         smp;
      gorf_sample_s out;
      logic         strobe;
      logic         fifo_wr;
      logic         fifo_ovw;
      logic         fifo_drop;
      logic         lpf_en;
      logic [2:0]   lpf_set;
      gorf_rate_e   rate;
   } gorf_state_s;

   gorf_state_s s;
   gorf_state_s next_s;

   logic        hit;
   logic [7:0]  rd_byte;
   logic [5:0]  idx;
   logic        lpf_on;
   logic        div_eff;
   logic        tick;
   logic        sync_bit;
   logic [2:0]  sync_sel;
   logic [2:0]  lpf_set;
   gorf_rate_e  rate;
   logic [TICK_W-1:0] period_m1;
   gorf_sample_s adj;

   function automatic logic [15:0] add_offset(input logic [15:0] raw,
                                              input logic [7:0]  hi,
                                              input logic [7:0]  lo);
      return raw + {hi, lo};
   endfunction

   function automatic gorf_sample_s place_sync(input gorf_sample_s smp,
                                               input logic [2:0]   sel,
                                               input logic         b);
      gorf_sample_s r;
      r = smp;
      case (sel)
         SYNC_TEMP:    r.temp[0]    = b;
         SYNC_GYRO_X:  r.gyro_x[0]  = b;
         SYNC_GYRO_Y:  r.gyro_y[0]  = b;
         SYNC_GYRO_Z:  r.gyro_z[0]  = b;
         SYNC_ACCEL_X: r.accel_x[0] = b;
         SYNC_ACCEL_Y: r.accel_y[0] = b;
         SYNC_ACCEL_Z: r.accel_z[0] = b;
         default:      r = smp;
      endcase
      return r;
   endfunction

   gorf_sync_latch u_sync_latch (
      .clk     (CORE_CLK),
      .rst_n   (RST_N),
      .pin     (FRAME_SYNC_PIN),
      .capture (s.smp),
      .latched (sync_bit)
   );

   // Register decode
   always_comb
   begin
      idx     = PADDR[7:2];
      hit     = (PADDR[1:0] == 2'b00);
      rd_byte = 8'h00;
      case (idx)
         IDX_Y_OFFS_HI: rd_byte = s.y_offs_hi;
         IDX_Y_OFFS_LO: rd_byte = s.y_offs_lo;
         IDX_Z_OFFS_HI: rd_byte = s.z_offs_hi;
         IDX_Z_OFFS_LO: rd_byte = s.z_offs_lo;
         IDX_RATE_DIV:  rd_byte = s.rate_div;
         IDX_PATH_CFG:  rd_byte = s.path_cfg;
         IDX_GYRO_CFG:  rd_byte = s.gyro_cfg;
         default:       hit = 1'b0;
      endcase
   end

   // Filter and rate selection
   always_comb
   begin
      lpf_set = s.path_cfg[LPF_SET_LSB +: 3];
      sync_sel = s.path_cfg[SYNC_SEL_LSB +: 3];
      lpf_on = (s.gyro_cfg[BYPASS_LSB +: 2] == BYPASS_NONE);
      div_eff = lpf_on && (lpf_set != LPF_SET_LOW)
                && (lpf_set != LPF_SET_HIGH);
      if (!lpf_on)
      begin
         rate = RATE_32K;
      end
      else if ((lpf_set == LPF_SET_LOW) || (lpf_set == LPF_SET_HIGH))
      begin
         rate = RATE_8K;
      end
      else
      begin
         rate = RATE_1K;
      end
      case (rate)
         RATE_32K: period_m1 = TICK_W'(TICKS_32K_P - 1);
         RATE_8K:  period_m1 = TICK_W'(TICKS_8K_P - 1);
         default:  period_m1 = TICK_W'(TICKS_1K_P - 1);
      endcase
      tick = (s.tick_cnt >= period_m1);
      adj = RAW_SAMPLE;
      adj.gyro_y = add_offset(RAW_SAMPLE.gyro_y, s.y_offs_hi,
                              s.y_offs_lo);
      adj.gyro_z = add_offset(RAW_SAMPLE.gyro_z, s.z_offs_hi,
                              s.z_offs_lo);
   end

   always_comb
   begin
      next_s = s;
      next_s.strobe    = 1'b0;
      next_s.fifo_wr   = 1'b0;
      next_s.fifo_ovw  = 1'b0;
      next_s.fifo_drop = 1'b0;
      // APB: ready in the first access cycle
      case (s.apb)
         APB_IDLE:
         begin
            if (PSEL && !PENABLE)
            begin
               next_s.apb     = APB_ACK;
               next_s.pready  = 1'b1;
               next_s.pslverr = !hit;
               next_s.prdata  = (PWRITE || !hit) ? 32'h0 : {24'h0, rd_byte};
            end
         end
         APB_ACK:
         begin
            if (PSEL && PENABLE)
            begin
               next_s.apb     = APB_IDLE;
               next_s.pready  = 1'b0;
               next_s.pslverr = 1'b0;
               if (PWRITE && hit && PSTRB[0])
               begin
                  case (idx)
                     IDX_Y_OFFS_HI: next_s.y_offs_hi = PWDATA[7:0];
                     IDX_Y_OFFS_LO: next_s.y_offs_lo = PWDATA[7:0];
                     IDX_Z_OFFS_HI: next_s.z_offs_hi = PWDATA[7:0];
                     IDX_Z_OFFS_LO: next_s.z_offs_lo = PWDATA[7:0];
                     IDX_RATE_DIV:  next_s.rate_div  = PWDATA[7:0];
                     IDX_PATH_CFG:  next_s.path_cfg  = PWDATA[7:0];
                     IDX_GYRO_CFG:  next_s.gyro_cfg  = PWDATA[7:0];
                     default:       next_s.rate_div  = s.rate_div;
                  endcase
               end
            end
         end
         default:
         begin
            next_s.apb    = APB_IDLE;
            next_s.pready = 1'b0;
         end
      endcase
      // Internal rate tick and divided sample strobe
      next_s.tick_cnt = tick ? '0 : s.tick_cnt + 1'b1;
      next_s.smp = 1'b0;
      if (!div_eff)
      begin
         next_s.div_cnt = 8'h00;
         next_s.smp     = tick;
      end
      else if (tick)
      begin
         if (s.div_cnt >= s.rate_div)
         begin
            next_s.div_cnt = 8'h00;
            next_s.smp     = 1'b1;
         end
         else
         begin
            next_s.div_cnt = s.div_cnt + 8'h01;
         end
      end
      // Strobe updates outputs and pushes the FIFO
      if (s.smp)
      begin
         next_s.out    = place_sync(adj, sync_sel, sync_bit);
         next_s.strobe = 1'b1;
         if (FIFO_FULL && s.path_cfg[FIFO_MODE_BIT])
         begin
            next_s.fifo_drop = 1'b1;
         end
         else
         begin
            next_s.fifo_wr  = 1'b1;
            next_s.fifo_ovw = FIFO_FULL;
         end
      end
      next_s.lpf_en  = lpf_on;
      next_s.lpf_set = lpf_set;
      next_s.rate    = rate;
   end

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         s           <= '0;
         s.y_offs_hi <= REG_RESET;
         s.z_offs_hi <= REG_RESET;
         s.rate_div  <= REG_RESET;
         s.path_cfg  <= REG_RESET;
         s.gyro_cfg  <= REG_RESET;
         s.apb       <= APB_IDLE;
         s.rate      <= RATE_8K;
         s.lpf_en    <= 1'b1;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign PRDATA         = s.prdata;
   assign PREADY         = s.pready;
   assign PSLVERR        = s.pslverr;
   assign OUT_SAMPLE     = s.out;
   assign SAMPLE_STROBE  = s.strobe;
   assign FIFO_WR        = s.fifo_wr;
   assign FIFO_OVERWRITE = s.fifo_ovw;
   assign FIFO_DROP      = s.fifo_drop;
   assign LPF_ENABLE     = s.lpf_en;
   assign LPF_SETTING    = s.lpf_set;
   assign INTERNAL_RATE  = s.rate;

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_N);

   sequence smp_taken;
      s.smp;
   endsequence
   sequence z_hi_write;
      PSEL && PENABLE && PREADY && PWRITE && PSTRB[0]
      && (PADDR == reg_addr(IDX_Z_OFFS_HI));
   endsequence

   a_offset_z_add: assert property (
      smp_taken |=> (OUT_SAMPLE.gyro_z >> 1) ==
      (add_offset($past(RAW_SAMPLE.gyro_z), $past(s.z_offs_hi),
                  $past(s.z_offs_lo)) >> 1))
      else $error("gyro z output lacks user offset");
   a_offset_high_byte: assert property (
      z_hi_write |=> s.z_offs_hi == $past(PWDATA[7:0]))
      else $error("offset high byte not stored");
   a_divider_strobe: assert property (
      tick && div_eff && (s.div_cnt == s.rate_div) |=> s.smp)
      else $error("divided strobe missing");
   a_divider_hold: assert property (
      div_eff && (!tick || (s.div_cnt < s.rate_div)) |=> !s.smp)
      else $error("strobe before divider count");
   a_divider_ignored: assert property (
      !div_eff && tick |=> s.smp)
      else $error("divider applied when not effective");
   a_strobe_pushes: assert property (
      smp_taken |=> SAMPLE_STROBE && (FIFO_WR != FIFO_DROP))
      else $error("strobe did not update outputs and fifo");
   a_fifo_drop_full: assert property (
      (smp_taken and (FIFO_FULL && s.path_cfg[FIFO_MODE_BIT]))
      |=> FIFO_DROP && !FIFO_WR ##1 !FIFO_DROP)
      else $error("full fifo write not discarded");
   a_fifo_overwrite: assert property (
      (smp_taken and (FIFO_FULL && !s.path_cfg[FIFO_MODE_BIT]))
      |=> FIFO_WR && FIFO_OVERWRITE)
      else $error("full fifo write did not overwrite");
   a_sync_temp_place: assert property (
      (smp_taken and (sync_sel == SYNC_TEMP))
      |=> OUT_SAMPLE.temp[0] == $past(sync_bit))
      else $error("sync bit not placed in temperature");
   a_lpf_follow: assert property (
      1'b1 |=> LPF_ENABLE == ($past(s.gyro_cfg[1:0]) == BYPASS_NONE))
      else $error("filter enable wrong for bypass bits");
   a_rate_bypass: assert property (
      !lpf_on |=> INTERNAL_RATE == RATE_32K)
      else $error("bypass did not select 32 kHz");

endmodule // gorf_config
`default_nettype wire

// >>> verif/gorf_host_model.sv
// Host processor model: APB master that reaches the configuration
// registers. Assumes the slave answers with PREADY at a rising edge.
`timescale 1ns/1ps
`default_nettype none
module gorf_host_model
   import gorf_pkg::*;
(
   // Clock
   input  wire logic        CORE_CLK,
   // APB master
   output logic             PSEL,
   output logic             PENABLE,
   output logic             PWRITE,
   output logic [7:0]       PADDR,
   output logic [31:0]      PWDATA,
   output logic [3:0]       PSTRB,
   input  wire logic [31:0] PRDATA,
   input  wire logic        PREADY,
   input  wire logic        PSLVERR
);
   initial
   begin
      PSEL    = 1'b0;
      PENABLE = 1'b0;
      PWRITE  = 1'b0;
      PADDR   = 8'h00;
      PWDATA  = 32'h00000000;
      PSTRB   = 4'h0;
   end

   // One transfer; bit 7 of path_config always goes out as zero
   task automatic xfer(input logic wr, input logic [7:0] addr,
                       input logic [7:0] wd, output logic [7:0] rd,
                       output logic err);
      logic [7:0] wv;
      wv = (addr == {IDX_PATH_CFG, 2'b00}) ? (wd & 8'h7F) : wd;
      @(posedge CORE_CLK);
      PSEL    <= 1'b1;
      PWRITE  <= wr;
      PADDR   <= addr;
      PWDATA  <= {24'h000000, wv};
      PSTRB   <= 4'hF;
      @(posedge CORE_CLK);
      PENABLE <= 1'b1;
      do
         @(posedge CORE_CLK);
      while (PREADY !== 1'b1);
      rd = PRDATA[7:0];
      err = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
   endtask
endmodule // gorf_host_model
`default_nettype wire

// >>> verif/gyro_offset_rate_filter_config_tb.sv
// Self-checking bench for the gyro offset, rate and filter configuration
// block. Assumes the host model for APB and shortened tick counts.
`timescale 1ns/1ps
`default_nettype none
module gyro_offset_rate_filter_config_tb
   import gorf_pkg::*;
;
   localparam int T32 = 8;
   localparam int T8  = 16;
   localparam int T1  = 32;
   localparam logic [5:0] IDX_TAB [0:6] = '{IDX_Y_OFFS_HI, IDX_Y_OFFS_LO,
      IDX_Z_OFFS_HI, IDX_Z_OFFS_LO, IDX_RATE_DIV, IDX_PATH_CFG, IDX_GYRO_CFG};

   logic         clk = 1'b0;
   logic         rst_n = 1'b0;
   logic         psel, penable, pwrite, pready, pslverr;
   logic [7:0]   paddr;
   logic [31:0]  pwdata, prdata;
   logic [3:0]   pstrb;
   gorf_sample_s raw = '0;
   gorf_sample_s out;
   logic         sync_pin = 1'b0;
   logic         fifo_full = 1'b0;
   logic         strobe, fifo_wr, fifo_ovr, fifo_drop, lpf_en;
   logic [2:0]   lpf_set;
   gorf_rate_e   rate;
   int           miscompares = 0;
   int           n_tests = 0;

   gorf_config #(.TICKS_32K_P(T32), .TICKS_8K_P(T8), .TICKS_1K_P(T1)) dut_u (
      .CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .RAW_SAMPLE(raw), .FRAME_SYNC_PIN(sync_pin), .OUT_SAMPLE(out),
      .SAMPLE_STROBE(strobe), .FIFO_FULL(fifo_full), .FIFO_WR(fifo_wr),
      .FIFO_OVERWRITE(fifo_ovr), .FIFO_DROP(fifo_drop),
      .LPF_ENABLE(lpf_en), .LPF_SETTING(lpf_set), .INTERNAL_RATE(rate));

   gorf_host_model host_u (
      .CORE_CLK(clk), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr));

   initial
   begin
      forever #2 clk = ~clk;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input string what, input logic [111:0] exp,
                        input logic [111:0] got);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      logic [7:0] rd;
      logic       err;
      host_u.xfer(1'b1, {idx, 2'b00}, d, rd, err);
   endtask

   task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
      logic [7:0] rd;
      logic       err;
      host_u.xfer(1'b0, {idx, 2'b00}, 8'h00, rd, err);
      check("register", 112'({err, rd}), 112'({1'b0, exp}));
   endtask

   // Counts edges up to the next sample strobe
   task automatic wait_strobe(output int gap);
      gap = 0;
      do
      begin
         @(posedge clk);
         gap++;
      end
      while (strobe !== 1'b1 && gap < 10000);
   endtask

   function automatic int exp_gap(input logic [1:0] b, input logic [2:0] lp,
                                  input int d);
      if (b != 2'b00)
         return T32;
      if (lp == 3'h0 || lp == 3'h7)
         return T8;
      return T1 * (d + 1);
   endfunction

   function automatic gorf_rate_e exp_rate(input logic [1:0] b,
                                           input logic [2:0] lp);
      if (b != 2'b00)
         return RATE_32K;
      return (lp == 3'h0 || lp == 3'h7) ? RATE_8K : RATE_1K;
   endfunction

   function automatic gorf_sample_s exp_sample(input gorf_sample_s r,
      input logic [15:0] yo, input logic [15:0] zo, input logic [2:0] sel,
      input logic s);
      gorf_sample_s e;
      e = r;
      e.gyro_y = r.gyro_y + yo;
      e.gyro_z = r.gyro_z + zo;
      if (sel != SYNC_OFF)
         e[(7 - sel) * 16] = s;
      return e;
   endfunction

   initial
   begin
      #400000;
      miscompares++;
      conclude();
   end

   initial
   begin
      int          seed;
      int          gap;
      int          d;
      logic [1:0]  b;
      logic [2:0]  lp;
      logic [15:0] yo, zo;
      logic [7:0]  r8;
      logic        err;
      seed = $urandom(10);
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check("lpf enable", 112'(1'b1), 112'(lpf_en));
      check("rate", 112'(RATE_8K), 112'(rate));
      for (int i = 0; i < 7; i++)
         rd_chk(IDX_TAB[i], 8'h00);
      for (int i = 0; i < 7; i++)
      begin
         d = $urandom;
         wr(IDX_TAB[i], d[7:0]);
         rd_chk(IDX_TAB[i], (IDX_TAB[i] == IDX_PATH_CFG) ?
                (d[7:0] & 8'h7F) : d[7:0]);
      end
      // Misaligned write and unmapped read are refused
      wr(IDX_RATE_DIV, 8'h5A);
      host_u.xfer(1'b1, {IDX_RATE_DIV, 2'b01}, 8'hA5, r8, err);
      check("misaligned error", 112'(1'b1), 112'(err));
      rd_chk(IDX_RATE_DIV, 8'h5A);
      host_u.xfer(1'b0, {IDX_RATE_DIV, 2'b10}, 8'h00, r8, err);
      check("misaligned read", 112'(9'h100), 112'({err, r8}));
      host_u.xfer(1'b0, 8'hFC, 8'h00, r8, err);
      check("unmapped read", 112'(9'h100), 112'({err, r8}));
      for (int i = 0; i < 32; i++)
      begin
         b = i[4:3];
         lp = i[2:0];
         wr(IDX_GYRO_CFG, {6'h00, b});
         wr(IDX_PATH_CFG, {5'h00, lp});
         repeat (3) @(posedge clk);
         check("lpf", 112'({b == 2'b00, lp}),
               112'({lpf_en, lpf_set}));
         check("rate", 112'(exp_rate(b, lp)), 112'(rate));
      end
      for (int t = 0; t < 6; t++)
      begin
         b = (t < 3) ? 2'b00 : 2'($urandom);
         lp = (t == 0) ? 3'h6 : (t == 1) ? 3'h7 : 3'($urandom);
         d = (t == 0) ? 255 : $urandom % 6;
         wr(IDX_RATE_DIV, d[7:0]);
         wr(IDX_GYRO_CFG, {6'h00, b});
         wr(IDX_PATH_CFG, {5'h00, lp});
         repeat (3) wait_strobe(gap);
         check("strobe gap", 112'(exp_gap(b, lp, d)),
               112'(gap));
      end
      yo = 16'($urandom);
      zo = 16'($urandom);
      wr(IDX_GYRO_CFG, 8'h00);
      wr(IDX_RATE_DIV, 8'h00);
      wr(IDX_Y_OFFS_HI, yo[15:8]);
      wr(IDX_Y_OFFS_LO, yo[7:0]);
      wr(IDX_Z_OFFS_HI, zo[15:8]);
      wr(IDX_Z_OFFS_LO, zo[7:0]);
      for (int s = 0; s < 16; s++)
      begin
         wr(IDX_PATH_CFG, {1'b0, s[3], s[2:0], 3'h0});
         @(posedge clk);
         raw <= 112'({$urandom, $urandom, $urandom, $urandom});
         fifo_full <= 1'($urandom);
         sync_pin <= ~sync_pin;
         repeat (2) wait_strobe(gap);
         check("sample",
               exp_sample(raw, yo, zo, s[2:0], sync_pin), out);
         check("fifo push",
               112'({~fifo_full | ~s[3], fifo_full & ~s[3],
               fifo_full & s[3]}), 112'({fifo_wr, fifo_ovr, fifo_drop}));
      end
      conclude();
   end
endmodule // gyro_offset_rate_filter_config_tb
`default_nettype wire
